// ### hw/spo_pkg.sv
// Function
// - Input B reference scale at bits [3:2] of the reference register: 00 div1, 01 div4, 10 div8, 11 div16.
// - Input A reference scale at bits [1:0] of the reference register with the same encoding.
// - Channel 1 output scale at bits [3:2] of the channel register: 00 div1, 01 div4, 10 div8, 11 div16.
// - Channel 0 output scale at bits [1:0]: 00 div1, 01 div4, 10 div8, 11 div16.
// - Bit 4 of the loop register picks the 70 degree filter at 0 and the 88.5 degree filter at 1.
// - Loop bandwidth from bits [3:2]: 00 50 Hz, 01 1 Hz, 10 10 Hz, 11 100 Hz.
// - Tolerance from bits [1:0]: 00 10%/8%, 01 12/9.6 ppm, 10 48/38 ppm, 11 200/160 ppm.
// - Writing 1 to bit 0 of the start-transfer register launches a ROM download without reset.
// - The start-transfer bit clears itself when that download finishes.
// - Writing 1 to bit 0 of the override-reset register soft-resets the core and starts a download.
// - The override-reset bit returns to zero when its download completes.
// - Overrides act only when the section enable is 1 and the pin strap select input is low.
// - A read-only status bit stays high while a ROM read is under way.
// - A successful ROM load sets a latched event flag unless masked, cleared only by clear or reset.
package spo_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [15:0] ADDR_SECTION_EN = 16'h0C03;
    localparam logic [15:0] ADDR_REF_SCALE = 16'h0C04;
    localparam logic [15:0] ADDR_OUT_SCALE = 16'h0C05;
    localparam logic [15:0] ADDR_LOOP_SEL = 16'h0C06;
    localparam logic [15:0] ADDR_START_XFER = 16'h0C07;
    localparam logic [15:0] ADDR_OVR_RESET = 16'h0C08;
    localparam logic [15:0] ADDR_ROM_STATUS = 16'h0D00;
    localparam logic [15:0] ADDR_EVENT = 16'h0D03;
    localparam logic [15:0] ADDR_EVENT_CTL = 16'h0C0F;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int SCALE_HI_POS = 2;
    localparam int SCALE_LO_POS = 0;
    localparam int FILTER_POS = 4;
    localparam int TRIG_POS = 0;
    localparam int BUSY_POS = 3;
    localparam int DONE_EV_POS = 4;
    localparam int EV_MASK_POS = 0;
    localparam int EV_CLR_POS = 1;
    localparam logic [7:0] REF_SCALE_RST = 8'h00;
    localparam logic [7:0] OUT_SCALE_RST = 8'h00;
    localparam logic [7:0] LOOP_SEL_RST = 8'h00;
    localparam logic [7:0] SCALE_MASK = 8'h0F;
    localparam logic [7:0] LOOP_MASK = 8'h1F;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int ROM_LOAD_US = 10;
    localparam int ROM_LOAD_CYC = ROM_LOAD_US * CLK_MHZ;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        SPO_IDLE = 2'b00,
        SPO_LOAD = 2'b01,
        SPO_DONE = 2'b10
    } spo_state_e;

    typedef struct packed {
        logic [4:0] ref_b_div;
        logic [4:0] ref_a_div;
        logic [4:0] ch1_div;
        logic [4:0] ch0_div;
        logic high_margin_filter_select;
        logic [1:0] loop_bw_code;
        logic [1:0] tol_code;
        logic active;
    } spo_cfg_s;
endpackage

// ### hw/spo_rom_seq.sv
`timescale 1ns/1ns
`default_nettype none
module spo_rom_seq #(
    parameter int LOAD_CYC = spo_pkg::ROM_LOAD_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    output logic o_busy,
    output logic o_done
);
    import spo_pkg::*;

    spo_state_e state_q;
    spo_state_e state_d;
    logic [15:0] cnt_q;
    wire cnt_end = (cnt_q == 16'(LOAD_CYC - 1));

    // Next state of the download sequencer.
    always_comb begin
        case (state_q)
            SPO_IDLE: state_d = i_start ? SPO_LOAD : SPO_IDLE;
            SPO_LOAD: state_d = cnt_end ? SPO_DONE : SPO_LOAD;
            SPO_DONE: state_d = SPO_IDLE;
            default: state_d = SPO_IDLE;
        endcase
    end

    // State and length counter.
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            state_q <= SPO_IDLE;
            cnt_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            cnt_q <= (state_q == SPO_LOAD) ? cnt_q + 16'h0001 : 16'h0000;
        end
    end

    assign o_busy = (state_q == SPO_LOAD);
    assign o_done = (state_q == SPO_DONE);
endmodule
`default_nettype wire

// ### hw/spo_bank.sv
`timescale 1ns/1ns
`default_nettype none
module spo_bank #(
    parameter int LOAD_CYC = spo_pkg::ROM_LOAD_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_pin_strap_select,
    output spo_pkg::spo_cfg_s o_cfg,
    output logic o_rom_busy,
    output logic o_soft_reset
);
    import spo_pkg::*;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // One write select per writable register.
    wire wr_en = i_wr && (i_addr == ADDR_SECTION_EN);
    wire wr_ref = i_wr && (i_addr == ADDR_REF_SCALE);
    wire wr_out = i_wr && (i_addr == ADDR_OUT_SCALE);
    wire wr_loop = i_wr && (i_addr == ADDR_LOOP_SEL);
    wire wr_xfer = i_wr && (i_addr == ADDR_START_XFER);
    wire wr_ovr = i_wr && (i_addr == ADDR_OVR_RESET);
    wire wr_evc = i_wr && (i_addr == ADDR_EVENT_CTL);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic en_q;
    logic [7:0] ref_q;
    logic [7:0] out_q;
    logic [7:0] loop_q;
    logic xfer_q;
    logic ovr_q;
    logic ev_mask_q;
    logic ev_done_q;
    logic soft_rst_q;
    logic [7:0] rdata_q;
    logic rom_busy;
    logic rom_done;

    // A trigger write only launches a download when none is running.
    // start transfer
    wire start_xfer = wr_xfer && i_wdata[TRIG_POS];
    wire start_ovr = wr_ovr && i_wdata[TRIG_POS];
    wire rom_start = (start_xfer || start_ovr) && !rom_busy && !xfer_q && !ovr_q;

    // Configuration registers keep only their defined bits.
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            en_q <= 1'b0;
            ref_q <= REF_SCALE_RST;
            out_q <= OUT_SCALE_RST;
            loop_q <= LOOP_SEL_RST;
            ev_mask_q <= 1'b0;
        end else begin
            if (wr_en) en_q <= i_wdata[0];
            if (wr_ref) ref_q <= i_wdata & SCALE_MASK;
            if (wr_out) out_q <= i_wdata & SCALE_MASK;
            if (wr_loop) loop_q <= i_wdata & LOOP_MASK;
            if (wr_evc) ev_mask_q <= i_wdata[EV_MASK_POS];
        end
    end

    // Self-clearing triggers; the done of their download drops them.
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            xfer_q <= 1'b0;
            ovr_q <= 1'b0;
            soft_rst_q <= 1'b0;
        end else begin
            if (rom_done) xfer_q <= 1'b0;
            else if (rom_start && start_xfer) xfer_q <= 1'b1;
            if (rom_done) ovr_q <= 1'b0;
            else if (rom_start && start_ovr) ovr_q <= 1'b1;
            soft_rst_q <= rom_start && start_ovr;
        end
    end

    // Latched load-complete event; a new event wins over a clear.
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            ev_done_q <= 1'b0;
        end else begin
            if (rom_done && !ev_mask_q) ev_done_q <= 1'b1;
            else if (wr_evc && i_wdata[EV_CLR_POS]) ev_done_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Download sequencer
    // ----------------------------------------
    spo_rom_seq #(
        .LOAD_CYC(LOAD_CYC)
    ) u_seq (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_start(rom_start),
        .o_busy(rom_busy),
        .o_done(rom_done)
    );

    // ----------------------------------------
    // Read back
    // ----------------------------------------
    // Read mux; unmapped addresses return zero.
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (i_addr)
            ADDR_SECTION_EN: rd_mux = {7'h00, en_q};
            ADDR_REF_SCALE: rd_mux = ref_q;
            ADDR_OUT_SCALE: rd_mux = out_q;
            ADDR_LOOP_SEL: rd_mux = loop_q;
            ADDR_START_XFER: rd_mux = {7'h00, xfer_q};
            ADDR_OVR_RESET: rd_mux = {7'h00, ovr_q};
            ADDR_ROM_STATUS: rd_mux = 8'(rom_busy) << BUSY_POS;
            ADDR_EVENT: rd_mux = 8'(ev_done_q) << DONE_EV_POS;
            ADDR_EVENT_CTL: rd_mux = {7'h00, ev_mask_q};
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data registered for the cycle after the strobe.
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) rdata_q <= 8'h00;
        else rdata_q <= i_rd ? rd_mux : 8'h00;
    end

    // ----------------------------------------
    // Decoded overrides
    // ----------------------------------------
    // Scale code to divide ratio: 1, 4, 8 or 16.
    function automatic logic [4:0] div_of(input logic [1:0] code);
        case (code)
            2'b00: div_of = 5'h01;
            2'b01: div_of = 5'h04;
            2'b10: div_of = 5'h08;
            2'b11: div_of = 5'h10;
            default: div_of = 5'h01;
        endcase
    endfunction

    spo_cfg_s cfg_d;
    spo_cfg_s cfg_q;
    // Overrides gated by the section enable and the strap pin.
    always_comb begin
        cfg_d.active = en_q && !i_pin_strap_select;
        cfg_d.ref_b_div = div_of(ref_q[SCALE_HI_POS +: 2]);
        cfg_d.ref_a_div = div_of(ref_q[SCALE_LO_POS +: 2]);
        cfg_d.ch1_div = div_of(out_q[SCALE_HI_POS +: 2]);
        cfg_d.ch0_div = div_of(out_q[SCALE_LO_POS +: 2]);
        cfg_d.high_margin_filter_select = loop_q[FILTER_POS];
        cfg_d.loop_bw_code = loop_q[SCALE_HI_POS +: 2];
        cfg_d.tol_code = loop_q[SCALE_LO_POS +: 2];
    end

    // Output flops for the configuration word.
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) cfg_q <= '0;
        else cfg_q <= cfg_d;
    end

    assign o_cfg = cfg_q;
    assign o_rdata = rdata_q;
    assign o_rom_busy = rom_busy;
    assign o_soft_reset = soft_rst_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_trig;
        rom_start;
    endsequence
    sequence s_busy_run;
        o_rom_busy [*8];
    endsequence

    a_xfer_sets_bit: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        rom_start && start_xfer |=> xfer_q)
        else $error("start bit not set");
    a_xfer_clears: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        rom_done |=> !xfer_q && !ovr_q)
        else $error("trigger not cleared");
    a_ovr_soft_rst: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        rom_start && start_ovr |=> o_soft_reset && ovr_q)
        else $error("override reset not raised");
    a_ovr_held: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        ovr_q && !rom_done |=> ovr_q)
        else $error("override bit dropped early");
    a_busy_after_go: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        s_trig |=> s_busy_run)
        else $error("busy not held");
    a_event_latch: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        rom_done && !ev_mask_q |=> ev_done_q)
        else $error("event not latched");
    a_gate_active: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        1'b1 |=> o_cfg.active == ($past(en_q) && !$past(i_pin_strap_select)))
        else $error("override gate wrong");
    a_chan0_top: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        out_q[1:0] == 2'b11 |=> o_cfg.ch0_div == 5'h10)
        else $error("channel 0 code 11 not div16");
    a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        ref_q[7:4] == 4'h0 && out_q[7:4] == 4'h0 && loop_q[7:5] == 3'h0)
        else $error("reserved bits stored");

    // ----------------------------------------
    // Checker helpers
    // ----------------------------------------
    // Field views and event conditions used by the checks below.
    wire [1:0] chk_ref_b = ref_q[SCALE_HI_POS +: 2];
    wire [1:0] chk_ref_a = ref_q[SCALE_LO_POS +: 2];
    wire [1:0] chk_ch1 = out_q[SCALE_HI_POS +: 2];
    wire [1:0] chk_ch0 = out_q[SCALE_LO_POS +: 2];
    wire [1:0] chk_bw = loop_q[SCALE_HI_POS +: 2];
    wire [1:0] chk_tol = loop_q[SCALE_LO_POS +: 2];
    wire chk_ev_clr = wr_evc && i_wdata[EV_CLR_POS];
    wire chk_ev_set = rom_done && !ev_mask_q;

    // Counts the cycles of the running download, since the full length is too long to repeat.
    logic [15:0] chk_busy_q;
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) chk_busy_q <= 16'h0000;
        else if (rom_busy) chk_busy_q <= chk_busy_q + 16'h0001;
        else chk_busy_q <= 16'h0000;
    end

    // Each ratio is one for code 00 and otherwise two shifted left by the code.
    a_ref_b_ratio: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        1'b1 |=> o_cfg.ref_b_div ==
            (($past(chk_ref_b) == 2'b00) ? 5'h01 : 5'h02 << $past(chk_ref_b)))
        else $error("input B ratio wrong");
    a_ref_a_ratio: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        1'b1 |=> o_cfg.ref_a_div ==
            (($past(chk_ref_a) == 2'b00) ? 5'h01 : 5'h02 << $past(chk_ref_a)))
        else $error("input A ratio wrong");
    a_ch1_ratio: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        1'b1 |=> o_cfg.ch1_div ==
            (($past(chk_ch1) == 2'b00) ? 5'h01 : 5'h02 << $past(chk_ch1)))
        else $error("channel 1 ratio wrong");
    a_ch0_ratio: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        1'b1 |=> o_cfg.ch0_div ==
            (($past(chk_ch0) == 2'b00) ? 5'h01 : 5'h02 << $past(chk_ch0)))
        else $error("channel 0 ratio wrong");

    // Loop fields pass to the configuration word one cycle later.
    a_filter_follow: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        1'b1 |=> o_cfg.high_margin_filter_select == $past(loop_q[FILTER_POS]))
        else $error("filter select not followed");
    a_bw_follow: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        1'b1 |=> o_cfg.loop_bw_code == $past(chk_bw))
        else $error("loop bandwidth code not followed");
    a_tol_follow: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        1'b1 |=> o_cfg.tol_code == $past(chk_tol))
        else $error("tolerance code not followed");

    // The busy bit stands for exactly the download length.
    a_busy_bounded: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        rom_busy |-> chk_busy_q < 16'(LOAD_CYC))
        else $error("download runs too long");
    a_busy_length: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        rom_done |-> chk_busy_q == 16'(LOAD_CYC))
        else $error("download length wrong");

    // Only an unmasked done sets the event, and only a clear without a set drops it.
    a_event_clear: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        chk_ev_clr && !chk_ev_set |=> !ev_done_q)
        else $error("event not cleared");
    a_event_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        ev_done_q && !chk_ev_clr |=> ev_done_q)
        else $error("event dropped without clear");
    a_event_masked: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        !ev_done_q && !chk_ev_set |=> !ev_done_q)
        else $error("event set without cause");

    // Trigger bits last until their download is done, and the soft reset is one pulse.
    a_xfer_held: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        xfer_q && !rom_done |=> xfer_q)
        else $error("start bit dropped early");
    a_done_ends_busy: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        $fell(rom_busy) |-> rom_done)
        else $error("busy ended without done");
    a_soft_rst_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_soft_reset |=> !o_soft_reset)
        else $error("soft reset longer than a cycle");
    a_map_kept: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_soft_reset |-> $stable(ref_q) && $stable(out_q) && $stable(loop_q))
        else $error("map changed by override reset");
    a_one_trigger: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        !(xfer_q && ovr_q))
        else $error("both triggers set");

    // Read-back of triggers, status and reserved bits in the cycle after the strobe.
    a_start_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_rd && i_addr == ADDR_START_XFER |=> o_rdata == {7'h00, $past(xfer_q)})
        else $error("start bit read wrong");
    a_busy_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_rd && i_addr == ADDR_ROM_STATUS |=> o_rdata[BUSY_POS] == $past(rom_busy))
        else $error("busy bit read wrong");
    a_event_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_rd && i_addr == ADDR_EVENT |=> o_rdata[DONE_EV_POS] == $past(ev_done_q))
        else $error("event bit read wrong");
    a_ref_rsvd_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_rd && i_addr == ADDR_REF_SCALE |=> o_rdata[7:4] == 4'h0)
        else $error("reference reserved bits read back");
    a_out_rsvd_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_rd && i_addr == ADDR_OUT_SCALE |=> o_rdata[7:4] == 4'h0)
        else $error("channel reserved bits read back");
    a_loop_rsvd_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_rd && i_addr == ADDR_LOOP_SEL |=> o_rdata[7:5] == 3'h0)
        else $error("loop reserved bits read back");
    a_ovr_rsvd_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_rd && i_addr == ADDR_OVR_RESET |=> o_rdata[7:1] == 7'h00)
        else $error("override reserved bits read back");

    // Either the strap pin or a cleared enable keeps the overrides off.
    a_gate_strap: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_pin_strap_select |=> !o_cfg.active)
        else $error("override active with strap high");
    a_gate_enable: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        !en_q |=> !o_cfg.active)
        else $error("override active while disabled");
endmodule
`default_nettype wire

// ### test/spo_bank_tb.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import spo_pkg::*;
    localparam int LOAD = 8;
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_pin_strap_select = 1'b0;
    logic [7:0] o_rdata;
    spo_cfg_s o_cfg;
    logic o_rom_busy;
    logic o_soft_reset;
    logic [7:0] rd_val;
    logic [1:0] k;
    int fail_count = 0;
    int checked = 0;
    int pulses = 0;
    int busy_cyc = 0;

    // ----------------------------------------
    // Clock, device and monitors
    // ----------------------------------------
    // The clock toggles every half period of 25 ns.
    always #25 i_core_clk = ~i_core_clk;

    spo_bank #(.LOAD_CYC(LOAD)) i_dut (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_pin_strap_select(i_pin_strap_select),
        .o_cfg(o_cfg),
        .o_rom_busy(o_rom_busy),
        .o_soft_reset(o_soft_reset)
    );

    // Counts soft reset pulses and busy cycles seen at the ports.
    always @(posedge i_core_clk) begin
        if (o_soft_reset === 1'b1) pulses <= pulses + 1;
        if (o_rom_busy === 1'b1) busy_cyc <= busy_cyc + 1;
    end

    // ----------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compares one byte and reports a mismatch at once.
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // A write is one strobe cycle; a gap cycle follows the next call's wait.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    // Read data are taken in the one cycle after the strobe.
    task automatic rd(input logic [15:0] a);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] exp, input string what);
        rd(a);
        cmp8(rd_val, exp, what);
    endtask

    // Lets the registered configuration follow a write or strap change.
    task automatic settle();
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask

    // Waits, bounded, for the download to finish and the trigger to clear.
    task automatic wait_done();
        int n;
        n = 0;
        repeat (2) @(posedge i_core_clk);
        while (o_rom_busy !== 1'b0 && n < 100) begin
            @(posedge i_core_clk);
            n++;
        end
        if (n >= 100) begin
            fail_count++;
            $display("[FAIL] %0t download never ended", $time);
            tally_and_finish();
        end
        repeat (3) @(posedge i_core_clk);
    endtask

    function automatic logic [7:0] ratio(input logic [1:0] c);
        case (c)
            2'b00: return 8'h01;
            2'b01: return 8'h04;
            2'b10: return 8'h08;
            default: return 8'h10;
        endcase
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    // Runs the tests in order and ends with the verdict.
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        settle();
        rdc(ADDR_REF_SCALE, REF_SCALE_RST, "ref reset");
        rdc(ADDR_OUT_SCALE, OUT_SCALE_RST, "out reset");
        rdc(ADDR_LOOP_SEL, LOOP_SEL_RST, "loop reset");
        rdc(ADDR_START_XFER, 8'h00, "start reset");
        rdc(ADDR_OVR_RESET, 8'h00, "ovr reset");
        cmp8({7'h0, o_cfg.active}, 8'h00, "inactive at reset");
        $display("test reset done");
        wr(ADDR_SECTION_EN, 8'h01);
        for (int c = 0; c < 4; c++) begin
            k = c[1:0];
            wr(ADDR_REF_SCALE, {4'hF, k, ~k});
            wr(ADDR_OUT_SCALE, {4'hF, k, ~k});
            wr(ADDR_LOOP_SEL, {3'h7, k[0], k, ~k});
            settle();
            cmp8({3'h0, o_cfg.ref_b_div}, ratio(k), "ref b");
            cmp8({3'h0, o_cfg.ref_a_div}, ratio(~k), "ref a");
            cmp8({3'h0, o_cfg.ch1_div}, ratio(k), "ch1");
            cmp8({3'h0, o_cfg.ch0_div}, ratio(~k), "ch0");
            cmp8({7'h0, o_cfg.high_margin_filter_select}, {7'h0, k[0]}, "filter");
            cmp8({6'h0, o_cfg.loop_bw_code}, {6'h0, k}, "bw");
            cmp8({6'h0, o_cfg.tol_code}, {6'h0, ~k}, "tol");
            cmp8({7'h0, o_cfg.active}, 8'h01, "active");
            rdc(ADDR_REF_SCALE, {4'h0, k, ~k}, "ref rsvd");
            rdc(ADDR_OUT_SCALE, {4'h0, k, ~k}, "out rsvd");
            rdc(ADDR_LOOP_SEL, {3'h0, k[0], k, ~k}, "loop rsvd");
        end
        $display("test scales done");
        @(posedge i_core_clk);
        i_pin_strap_select <= 1'b1;
        settle();
        cmp8({7'h0, o_cfg.active}, 8'h00, "strap high");
        @(posedge i_core_clk);
        i_pin_strap_select <= 1'b0;
        wr(ADDR_SECTION_EN, 8'h00);
        settle();
        cmp8({7'h0, o_cfg.active}, 8'h00, "enable off");
        $display("test gating done");
        wr(ADDR_EVENT_CTL, 8'h00);
        busy_cyc = 0;
        wr(ADDR_START_XFER, 8'hFF);
        rdc(ADDR_START_XFER, 8'h01, "start set");
        rd(ADDR_ROM_STATUS);
        cmp8({7'h0, rd_val[BUSY_POS]}, 8'h01, "busy bit");
        wait_done();
        cmp8(busy_cyc[7:0], LOAD[7:0], "busy length");
        rdc(ADDR_START_XFER, 8'h00, "start cleared");
        rd(ADDR_ROM_STATUS);
        cmp8({7'h0, rd_val[BUSY_POS]}, 8'h00, "busy cleared");
        rd(ADDR_EVENT);
        cmp8({7'h0, rd_val[DONE_EV_POS]}, 8'h01, "event set");
        rd(ADDR_EVENT);
        cmp8({7'h0, rd_val[DONE_EV_POS]}, 8'h01, "event held");
        wr(ADDR_EVENT_CTL, 8'h02);
        rd(ADDR_EVENT);
        cmp8({7'h0, rd_val[DONE_EV_POS]}, 8'h00, "event clear");
        $display("test start transfer done");
        wr(ADDR_REF_SCALE, 8'h06);
        pulses = 0;
        wr(ADDR_OVR_RESET, 8'h01);
        rdc(ADDR_OVR_RESET, 8'h01, "ovr set");
        wait_done();
        cmp8(pulses[7:0], 8'h01, "soft reset pulse");
        rdc(ADDR_OVR_RESET, 8'h00, "ovr cleared");
        rdc(ADDR_REF_SCALE, 8'h06, "map kept");
        rd(ADDR_EVENT);
        cmp8({7'h0, rd_val[DONE_EV_POS]}, 8'h01, "ovr event");
        $display("test override reset done");
        wr(ADDR_EVENT_CTL, 8'h03);
        wr(ADDR_START_XFER, 8'h01);
        wait_done();
        rd(ADDR_EVENT);
        cmp8({7'h0, rd_val[DONE_EV_POS]}, 8'h00, "masked event");
        wr(16'h0123, 8'hFF);
        rdc(16'h0123, 8'h00, "unmapped");
        rdc(ADDR_REF_SCALE, 8'h06, "unmapped write");
        $display("test mask and unmapped done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
